// ---- hdl/ccs_pkg.sv ----
package ccs_pkg;

   localparam int CCS_W = 8;

   // Event bit positions, bit 7 down to bit 0
   localparam int EV_PON = 7;
   localparam int EV_URQ = 6;
   localparam int EV_CME = 5;
   localparam int EV_EXE = 4;
   localparam int EV_DDE = 3;
   localparam int EV_QYE = 2;
   localparam int EV_RQC = 1;
   localparam int EV_OPC = 0;

   // Status byte positions
   localparam int SB_ESB1 = 7;
   localparam int SB_ESB  = 5;
   localparam int SB_MAV  = 4;
   localparam int SB_ESB0 = 3;
   localparam int SB_ERR  = 2;

   // Event bits that exist in the status register
   localparam logic [7:0] EV_USED_MASK = 8'hBD;
   localparam logic [7:0] MASK_RESET   = 8'h00;
   localparam logic [7:0] BYTE_ZERO    = 8'h00;
   localparam logic [7:0] OPC_REPLY    = 8'h01;

   typedef enum logic [3:0] {
      CCS_CMD_NONE  = 4'h0,
      CCS_CMD_OPC   = 4'h1,
      CCS_CMD_OPCQ  = 4'h2,
      CCS_CMD_WAI   = 4'h3,
      CCS_CMD_CLS   = 4'h4,
      CCS_CMD_ESE   = 4'h5,
      CCS_CMD_ESEQ  = 4'h6,
      CCS_CMD_ESRQ  = 4'h7,
      CCS_CMD_TRG   = 4'h8,
      CCS_CMD_OTHER = 4'h9
   } ccs_cmd_t;

   typedef struct packed {
      logic       valid;
      ccs_cmd_t   cmd;
      logic [7:0] arg;
   } ccs_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } ccs_resp_t;

endpackage : ccs_pkg

// ---- hdl/ccs_event_reg.sv ----
// Event status, enable mask and summary bit
module ccs_event_reg
   import ccs_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Control
   input  wire logic             clear,
   input  wire logic [CCS_W-1:0] set_bits,
   input  wire logic             mask_we,
   input  wire logic [CCS_W-1:0] mask_wdata,
   // State
   output logic      [CCS_W-1:0] status,
   output logic      [CCS_W-1:0] mask,
   output logic                  summary
);
   import ccs_pkg::*;

   typedef struct packed {
      logic [CCS_W-1:0] status;
      logic [CCS_W-1:0] mask;
      logic             summary;
   } ccs_ev_state_t;

   ccs_ev_state_t st_reg;
   ccs_ev_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      // Events arriving with a clear survive it
      if (clear)
      begin
         st_next.status = BYTE_ZERO;
      end
      st_next.status = (st_next.status | set_bits) & EV_USED_MASK;
      if (mask_we)
      begin
         st_next.mask = mask_wdata;
      end
      st_next.summary = |(st_next.status & st_next.mask);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '{status: BYTE_ZERO, mask: MASK_RESET, summary: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign status  = st_reg.status;
   assign mask    = st_reg.mask;
   assign summary = st_reg.summary;

endmodule : ccs_event_reg

// ---- hdl/ccs_status_byte.sv ----
// Status byte: latched ERR, ESB0 and ESB1 bits, with the event summary and MAV passed through
module ccs_status_byte
   import ccs_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Control
   input  wire logic             clear,
   input  wire logic             err_set,
   input  wire logic             esb0_set,
   input  wire logic             esb1_set,
   input  wire logic             summary,
   input  wire logic             msg_avail,
   // State
   output logic      [CCS_W-1:0] stb
);
   import ccs_pkg::*;

   typedef struct packed {
      logic err;
      logic esb0;
      logic esb1;
   } ccs_sb_state_t;

   ccs_sb_state_t st_reg;
   ccs_sb_state_t st_next;

   always_comb
   begin
      st_next = st_reg;
      if (clear)
      begin
         st_next = '0;
      end
      // Set wins over a simultaneous clear
      st_next.err  = st_next.err  | err_set;
      st_next.esb0 = st_next.esb0 | esb0_set;
      st_next.esb1 = st_next.esb1 | esb1_set;
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   always_comb
   begin
      stb          = BYTE_ZERO;
      stb[SB_ERR]  = st_reg.err;
      stb[SB_ESB0] = st_reg.esb0;
      stb[SB_ESB1] = st_reg.esb1;
      stb[SB_ESB]  = summary;
      stb[SB_MAV]  = msg_avail;
   end

endmodule : ccs_status_byte

// ---- hdl/ccs_sync_top.sv ----
// Synchronisation and status-event core of the command interpreter
module ccs_sync_top
   import ccs_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst,
   // Decoded commands from the parser
   input  ccs_pkg::ccs_req_t     req,
   output logic                  req_ready,
   // Operation engine
   input  wire logic             op_busy,
   output logic                  trig_pulse,
   output logic                  cmd_pass,
   output logic      [7:0]       cmd_pass_arg,
   output ccs_pkg::ccs_cmd_t     cmd_pass_code,
   // Events from the rest of the device
   input  wire logic [7:0]       ev_set,
   input  wire logic             err_set,
   input  wire logic             esb0_set,
   input  wire logic             esb1_set,
   input  wire logic             msg_avail,
   // Responses and status
   output ccs_pkg::ccs_resp_t    resp,
   output logic      [7:0]       status_byte,
   output logic      [7:0]       event_status,
   output logic                  err_clear
);
   import ccs_pkg::*;

   // Gray path: idle -> wait -> idle
   typedef enum logic [1:0] {
      CCS_IDLE = 2'b00,
      CCS_HOLD = 2'b01
   } ccs_state_t;

   typedef struct packed {
      ccs_state_t fsm;
      ccs_cmd_t   hold_cmd;
      logic       req_ready;
      logic       trig;
      logic       pass;
      logic [7:0] pass_arg;
      ccs_cmd_t   pass_code;
      ccs_resp_t  resp;
      logic [7:0] stb;
      logic [7:0] esr;
      logic       err_clear;
   } ccs_top_state_t;

   ccs_top_state_t st_reg;
   ccs_top_state_t st_next;

   logic [7:0] ev_status;
   logic [7:0] ev_mask;
   logic       ev_summary;
   logic [7:0] stb_now;
   logic       do_clear;
   logic [7:0] ev_set_all;
   logic       mask_we;
   logic       accept;
   logic       hold_done;
   logic       opc_done;
   logic       opq_done;

   function automatic logic is_cmd(ccs_req_t r, ccs_cmd_t c);
      return r.valid && (r.cmd == c);
   endfunction : is_cmd

   // Every answer is a one-cycle valid with its byte
   function automatic ccs_resp_t reply(logic [7:0] d);
      return '{valid: 1'b1, data: d};
   endfunction : reply

   // Commands are taken only when ready; triggers always
   assign accept = req.valid && (st_reg.fsm == CCS_IDLE
                                 || req.cmd == CCS_CMD_TRG);

   // Hold ends on the first edge that sees the engine idle
   always_comb
   begin
      hold_done = (st_reg.fsm == CCS_HOLD) && !op_busy;
      opc_done  = 1'b0;
      opq_done  = 1'b0;
      if (hold_done)
      begin
         unique case (st_reg.hold_cmd)
            CCS_CMD_OPC:
            begin
               opc_done = 1'b1;
            end
            CCS_CMD_OPCQ:
            begin
               opq_done = 1'b1;
            end
            CCS_CMD_WAI:
            begin
               // Plain wait never touches the event register
               opc_done = 1'b0;
            end
            default:
            begin
               opc_done = 1'b0;
            end
         endcase
      end
   end

   always_comb
   begin
      do_clear   = 1'b0;
      mask_we    = 1'b0;
      ev_set_all = ev_set;
      if (accept && is_cmd(req, CCS_CMD_CLS))
      begin
         do_clear = 1'b1;
      end
      if (accept && is_cmd(req, CCS_CMD_ESE))
      begin
         mask_we = 1'b1;
      end
      // Completion flag only for the plain completion command
      if (opc_done)
      begin
         ev_set_all[EV_OPC] = 1'b1;
      end
   end

   ccs_event_reg u_event_reg (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .clear      (do_clear),
      .set_bits   (ev_set_all),
      .mask_we    (mask_we),
      .mask_wdata (req.arg),
      .status     (ev_status),
      .mask       (ev_mask),
      .summary    (ev_summary)
   );

   ccs_status_byte u_status_byte (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .clear     (do_clear),
      .err_set   (err_set),
      .esb0_set  (esb0_set),
      .esb1_set  (esb1_set),
      .summary   (ev_summary),
      .msg_avail (msg_avail),
      .stb       (stb_now)
   );

   always_comb
   begin
      st_next            = st_reg;
      st_next.trig       = 1'b0;
      st_next.pass       = 1'b0;
      st_next.resp.valid = 1'b0;
      st_next.err_clear  = do_clear;
      st_next.stb        = stb_now;
      st_next.esr        = ev_status;
      unique case (st_reg.fsm)
         CCS_IDLE:
         begin
            if (accept)
            begin
               unique case (req.cmd)
                  CCS_CMD_OPC, CCS_CMD_OPCQ, CCS_CMD_WAI:
                  begin
                     // Hold off later commands except triggers until done
                     st_next.fsm      = CCS_HOLD;
                     st_next.hold_cmd = req.cmd;
                  end
                  CCS_CMD_ESEQ:
                  begin
                     st_next.resp = reply(ev_mask);
                  end
                  CCS_CMD_ESRQ:
                  begin
                     st_next.resp = reply(ev_status);
                  end
                  CCS_CMD_TRG:
                  begin
                     st_next.trig = 1'b1;
                  end
                  CCS_CMD_OTHER:
                  begin
                     st_next.pass      = 1'b1;
                     st_next.pass_arg  = req.arg;
                     st_next.pass_code = req.cmd;
                  end
                  CCS_CMD_CLS:
                  begin
                     // Clear path acts outside the state machine
                  end
                  CCS_CMD_ESE:
                  begin
                     // Mask write acts inside the event register
                  end
                  CCS_CMD_NONE:
                  begin
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
         CCS_HOLD:
         begin
            if (accept)
            begin
               st_next.trig = 1'b1;
            end
            if (hold_done)
            begin
               st_next.fsm = CCS_IDLE;
               if (opq_done)
               begin
                  st_next.resp = reply(OPC_REPLY);
               end
            end
         end
         default:
         begin
            st_next.fsm = CCS_IDLE;
         end
      endcase
      st_next.req_ready = (st_next.fsm == CCS_IDLE);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         st_reg.fsm       <= CCS_IDLE;
         st_reg.hold_cmd  <= CCS_CMD_NONE;
         st_reg.req_ready <= 1'b1;
         st_reg.trig      <= 1'b0;
         st_reg.pass      <= 1'b0;
         st_reg.pass_arg  <= BYTE_ZERO;
         st_reg.pass_code <= CCS_CMD_NONE;
         st_reg.resp      <= '{valid: 1'b0, data: BYTE_ZERO};
         st_reg.stb       <= BYTE_ZERO;
         st_reg.esr       <= BYTE_ZERO;
         st_reg.err_clear <= 1'b0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign req_ready     = st_reg.req_ready;
   assign trig_pulse    = st_reg.trig;
   assign cmd_pass      = st_reg.pass;
   assign cmd_pass_arg  = st_reg.pass_arg;
   assign cmd_pass_code = st_reg.pass_code;
   assign resp          = st_reg.resp;
   assign status_byte   = st_reg.stb;
   assign event_status  = st_reg.esr;
   assign err_clear     = st_reg.err_clear;

endmodule : ccs_sync_top

// ---- dv/ccs_op_model.sv ----
// Operation engine stand-in: busy for LEN cycles after each start
module ccs_op_model #(parameter int LEN = 12) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // Operation control
   input  wire logic start,
   output logic      op_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt_reg;
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         cnt_reg <= 0;
      else if (start)
         cnt_reg <= LEN;
      else if (cnt_reg != 0)
         cnt_reg <= cnt_reg - 1;
   assign op_busy = (cnt_reg != 0);
endmodule : ccs_op_model

// ---- dv/ccs_sync_assertions.sv ----
module ccs_sync_assertions
   import ccs_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // Watched ports
   input  ccs_pkg::ccs_req_t  req,
   input  wire logic       req_ready,
   input  wire logic       op_busy,
   input  wire logic       trig_pulse,
   input  ccs_pkg::ccs_resp_t resp,
   input  wire logic [7:0] ev_set,
   input  wire logic [7:0] event_status,
   input  wire logic       err_clear
);
   timeunit 1ns;
   timeprecision 1ns;
   logic take;
   assign take = req.valid && req_ready;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_unused_zero: assert property (!event_status[6] && !event_status[1])
      else $error("unused event bit set");
   a_clear_all: assert property (take && req.cmd == CCS_CMD_CLS &&
      ev_set == 8'h00 ##1 ev_set == 8'h00 |-> err_clear ##1 event_status == 8'h00)
      else $error("clear-status incomplete");
   a_hold_start: assert property (take && req.cmd inside
      {CCS_CMD_OPC, CCS_CMD_OPCQ, CCS_CMD_WAI} |=> !req_ready)
      else $error("no hold after sync command");
   a_hold_keep: assert property (!req_ready && op_busy |=> !req_ready)
      else $error("hold ended while busy");
   a_trig_pass: assert property (req.valid && req.cmd == CCS_CMD_TRG |=> trig_pulse)
      else $error("trigger not taken");
   a_reply_one: assert property (take && req.cmd == CCS_CMD_OPCQ &&
      !op_busy ##1 !op_busy |-> ##[1:2] (resp.valid && resp.data == OPC_REPLY))
      else $error("completion reply missing");
   a_done_bit: assert property (take && req.cmd == CCS_CMD_OPC ##1 !op_busy
      |-> ##[1:3] event_status[EV_OPC])
      else $error("completion bit not set");
   a_wait_clean: assert property (take && req.cmd == CCS_CMD_WAI &&
      !ev_set[EV_OPC] ##1 !event_status[EV_OPC] && !ev_set[EV_OPC]
      ##1 (!ev_set[EV_OPC]) [*3] |-> !event_status[EV_OPC])
      else $error("wait set completion bit");

   c_wait_busy: cover property (take && req.cmd == CCS_CMD_WAI && op_busy);
   c_reply: cover property (resp.valid && resp.data == OPC_REPLY);
   c_clear: cover property (err_clear);
   c_trig_hold: cover property (!req_ready && req.valid
      && req.cmd == CCS_CMD_TRG);
endmodule : ccs_sync_assertions

// ---- dv/tb_common_cmd_sync_status.sv ----
module tb_common_cmd_sync_status;
   import ccs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       ref_clk, rst, start, op_busy, req_ready, trig_pulse;
   logic       err_clear, err_set, esb0_set, esb1_set, msg_avail;
   logic [7:0] ev_set, status_byte, event_status;
   logic       cmd_pass;
   logic [7:0] cmd_pass_arg;
   ccs_cmd_t   cmd_pass_code;
   logic [7:0] mv [3] = '{8'hFF, 8'h24, 8'h00};
   ccs_req_t   req;
   ccs_resp_t  resp;
   int         fails, n_tests, cyc;

   ccs_op_model #(.LEN(12)) op_i (.ref_clk(ref_clk), .rst(rst),
      .start(start), .op_busy(op_busy));
   ccs_sync_top dut (.ref_clk(ref_clk), .rst(rst), .req(req),
      .req_ready(req_ready), .op_busy(op_busy), .trig_pulse(trig_pulse),
      .cmd_pass(cmd_pass), .cmd_pass_arg(cmd_pass_arg),
      .cmd_pass_code(cmd_pass_code), .ev_set(ev_set),
      .err_set(err_set), .esb0_set(esb0_set), .esb1_set(esb1_set),
      .msg_avail(msg_avail), .resp(resp), .status_byte(status_byte),
      .event_status(event_status), .err_clear(err_clear));

   task automatic chk(input string n, input logic [7:0] got, exp);
      n_tests++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk

   // Blocked requests stay presented until taken
   task automatic send(input ccs_cmd_t c, input logic [7:0] a);
      @(posedge ref_clk);
      req <= '{1'b1, c, a};
      do @(posedge ref_clk); while (!(req_ready || c == CCS_CMD_TRG));
      req <= '0;
   endtask : send

   task automatic query(input ccs_cmd_t c, input logic [7:0] e, string n);
      send(c, 8'h00);
      repeat (40)
      begin
         @(posedge ref_clk);
         if (resp.valid === 1'b1) break;
      end
      chk(n, resp.valid, 1'b1);
      chk(n, resp.data, e);
   endtask : query

   task automatic pulse(input logic [7:0] ev, input logic [2:0] f);
      @(posedge ref_clk);
      ev_set <= ev;
      {esb1_set, esb0_set, err_set} <= f;
      @(posedge ref_clk);
      ev_set <= 8'h00;
      {esb1_set, esb0_set, err_set} <= 3'b000;
      repeat (3) @(posedge ref_clk);
   endtask : pulse

   task automatic op();
      @(posedge ref_clk);
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
   endtask : op

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // Whole run needs well under 2000 cycles
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         give_verdict();
      end
   end

   initial
   begin
      {rst, start, err_set, esb0_set, esb1_set, msg_avail} = 6'b100000;
      req = '0;
      ev_set = 8'h00;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      query(CCS_CMD_ESEQ, 8'h00, "mask reset");
      foreach (mv[i])
      begin
         send(CCS_CMD_ESE, mv[i]);
         query(CCS_CMD_ESEQ, mv[i], "mask");
      end
      $display("test mask done");
      for (int i = 0; i < 8; i++)
      begin
         send(CCS_CMD_ESE, ~(8'h01 << i));
         pulse(8'h01 << i, 3'b000);
         chk("events", event_status, (8'h01 << i) & EV_USED_MASK);
         chk("esb off", status_byte[SB_ESB], 1'b0);
         send(CCS_CMD_ESE, 8'h01 << i);
         repeat (3) @(posedge ref_clk);
         chk("esb on", status_byte[SB_ESB], EV_USED_MASK[i]);
         send(CCS_CMD_CLS, 8'h00);
      end
      $display("test events done");
      msg_avail <= 1'b1;
      pulse(8'h80, 3'b111);
      chk("stb set", status_byte, 8'hBC);
      send(CCS_CMD_CLS, 8'h00);
      @(posedge ref_clk);
      chk("err clear", err_clear, 1'b1);
      repeat (3) @(posedge ref_clk);
      chk("stb clr", status_byte, 8'h10);
      chk("esr clr", event_status, 8'h00);
      $display("test clear done");
      for (int k = 0; k < 2; k++)
      begin
         if (k == 1) op();
         send(CCS_CMD_OPC, 8'h00);
         send(CCS_CMD_TRG, 8'h00);
         @(posedge ref_clk);
         chk("trigger", trig_pulse, 1'b1);
         query(CCS_CMD_ESRQ, 8'h01, "done bit");
         chk("busy", op_busy, 1'b0);
         send(CCS_CMD_CLS, 8'h00);
         if (k == 1) op();
         send(CCS_CMD_WAI, 8'h00);
         query(CCS_CMD_ESRQ, 8'h00, "wait esr");
         if (k == 1) op();
         query(CCS_CMD_OPCQ, OPC_REPLY, "reply");
         chk("busy", op_busy, 1'b0);
      end
      $display("test sync done");
      op();
      send(CCS_CMD_OPC, 8'h00);
      send(CCS_CMD_OTHER, 8'h5A);
      chk("pass busy", op_busy, 1'b0);
      @(posedge ref_clk);
      chk("pass", cmd_pass, 1'b1);
      chk("pass arg", cmd_pass_arg, 8'h5A);
      chk("pass code", cmd_pass_code, CCS_CMD_OTHER);
      $display("test pass done");
      give_verdict();
   end
endmodule : tb_common_cmd_sync_status

bind ccs_sync_top ccs_sync_assertions chk_i (
   .ref_clk      (ref_clk),
   .rst          (rst),
   .req          (req),
   .req_ready    (req_ready),
   .op_busy      (op_busy),
   .trig_pulse   (trig_pulse),
   .resp         (resp),
   .ev_set       (ev_set),
   .event_status (event_status),
   .err_clear    (err_clear)
);
